/* verilog/capture_timer_prescaler.sv */
`default_nettype none
module capture_timer_prescaler
  import ctp_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire prescale_cfg_t cfg,
  output logic               tap_tick_ff,
  output logic [TB_W-1:0]    time_base_ff,
  output logic               running_ff
);
  // --------------------------------------------------------------------------
  // Gear stage
  // --------------------------------------------------------------------------
  logic [PRE_W-1:0] gear_ticks;
  logic [PRE_W-1:0] idiv_ticks;
  logic [CHAIN_W-1:0] chain_ticks;
  logic             gear_en;
  logic             periph_en;
  logic             phi0_en;
  logic             tap_en;

  // Gear ticks come from a free divider on the oscillator clock.
  rate_divider #(.W(PRE_W)) u_gear (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .enable   (1'b1),
    .clear    (1'b0),
    .tick_ff  (gear_ticks)
  );

  // Gear selection; unlisted codes fall back to full rate.
  assign gear_en = (cfg.gear_code == GEAR_HALF)    ? gear_ticks[0] :
                   (cfg.gear_code == GEAR_QUARTER) ? gear_ticks[1] :
                   (cfg.gear_code == GEAR_EIGHTH)  ? gear_ticks[2] : 1'b1;
  // Oscillator source bypasses the gear completely.
  assign periph_en = (cfg.periph_src_select == SRC_OSC) ? 1'b1 : gear_en;

  // --------------------------------------------------------------------------
  // Input divider and binary chain
  // --------------------------------------------------------------------------
  rate_divider #(.W(PRE_W)) u_idiv (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .enable   (periph_en && cfg.divider_run),
    .clear    (!cfg.divider_run),
    .tick_ff  (idiv_ticks)
  );

  // Input-divide selection of the stage input rate.
  assign phi0_en = (cfg.input_divide_select == IDIV_2) ? idiv_ticks[0] :
                   (cfg.input_divide_select == IDIV_4) ? idiv_ticks[1] :
                   (cfg.input_divide_select == IDIV_8) ? idiv_ticks[2] :
                   idiv_ticks[3];

  // Chain runs only while run is set and is cleared otherwise.
  rate_divider #(.W(CHAIN_W)) u_chain (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .enable   (phi0_en && cfg.divider_run),
    .clear    (!cfg.divider_run),
    .tick_ff  (chain_ticks)
  );

  // Tap codes 0..7 select divide by 2..256; higher codes select no tap.
  assign tap_en = (cfg.tap_select < 4'h8) ? chain_ticks[cfg.tap_select[2:0]] : 1'b0;

  // --------------------------------------------------------------------------
  // Time-base counter and outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_tick_ff  <= 1'b0;
      time_base_ff <= '0;
      running_ff   <= 1'b0;
    end else begin
      tap_tick_ff <= tap_en && cfg.divider_run;
      running_ff  <= cfg.divider_run;
      if (tap_en && cfg.divider_run) begin
        time_base_ff <= time_base_ff + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Tick spacing monitor
  // --------------------------------------------------------------------------
  // The monitor measures the cycles between two tap ticks. It trusts the
  // spacing only after two ticks under an unchanged setting. Until then the
  // old gear, input-divide and chain phases can still shorten or stretch
  // one interval.
  localparam int SPAN_W       = 17;
  localparam int SHIFT_W      = 5;
  localparam int SETTLE_TICKS = 2;

  logic [SPAN_W-1:0] span_cnt_ff;
  logic [SPAN_W-1:0] nxt_span_cnt;
  logic [1:0]        settled_ff;
  logic [1:0]        nxt_settled;
  prescale_cfg_t     cfg_seen_ff;
  logic              cfg_moved;
  logic [SPAN_W-1:0] span_expected;

  // Returns log2 of the clock cycles between two tap ticks for a setting.
  function automatic logic [SHIFT_W-1:0] span_shift(input prescale_cfg_t c);
    logic [SHIFT_W-1:0] gear_sh;
    logic [SHIFT_W-1:0] idiv_sh;
    gear_sh = '0;
    if (c.periph_src_select == SRC_GEAR) begin
      if (c.gear_code == GEAR_HALF) begin
        gear_sh = SHIFT_W'(1);
      end else if (c.gear_code == GEAR_QUARTER) begin
        gear_sh = SHIFT_W'(2);
      end else if (c.gear_code == GEAR_EIGHTH) begin
        gear_sh = SHIFT_W'(3);
      end
    end
    idiv_sh = SHIFT_W'(PRE_W) - SHIFT_W'(c.input_divide_select);
    return gear_sh + idiv_sh + SHIFT_W'(c.tap_select) + SHIFT_W'(1);
  endfunction

  // Any change of the setting restarts the settling count.
  assign cfg_moved     = (cfg != cfg_seen_ff);
  assign span_expected = SPAN_W'(1) << span_shift(cfg);
  assign nxt_span_cnt  = tap_tick_ff ? SPAN_W'(1) :
                         (&span_cnt_ff) ? span_cnt_ff : span_cnt_ff + SPAN_W'(1);
  assign nxt_settled   = cfg_moved ? 2'h0 :
                         (tap_tick_ff && !(&settled_ff)) ? settled_ff + 2'h1 : settled_ff;

  // Registers of the spacing monitor.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      span_cnt_ff <= '0;
      settled_ff  <= '0;
      cfg_seen_ff <= '0;
    end else begin
      span_cnt_ff <= nxt_span_cnt;
      settled_ff  <= nxt_settled;
      cfg_seen_ff <= cfg;
    end
  end

  // Assertions.
  a_tick_spacing: assert property (@(posedge core_clk) disable iff (!rst_n)
    tap_tick_ff && !cfg_moved && (settled_ff >= SETTLE_TICKS) |->
    span_cnt_ff == span_expected) else $error("tap spacing wrong");
  a_stop_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
    !cfg.divider_run |=> (u_chain.count_ff == '0) && (u_idiv.count_ff == '0))
    else $error("divider not cleared");
  a_tick_needs_run: assert property (@(posedge core_clk) disable iff (!rst_n)
    tap_tick_ff |-> $past(cfg.divider_run)) else $error("tick without run");
  a_gear_src_used: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg.periph_src_select == SRC_GEAR |-> periph_en == gear_en)
    else $error("gear clock not used");
  a_gear_half_gap: assert property (@(posedge core_clk) disable iff (!rst_n)
    gear_ticks[0] |=> !gear_ticks[0]) else $error("half gear too fast");
  a_stop_no_tick: assert property (@(posedge core_clk) disable iff (!rst_n)
    !cfg.divider_run |=> !tap_tick_ff) else $error("tick while stopped");
  a_tb_follows_tick: assert property (@(posedge core_clk) disable iff (!rst_n)
    tap_tick_ff |-> time_base_ff == $past(time_base_ff) + 1'b1)
    else $error("time base missed tick");
  a_tb_holds_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    !tap_tick_ff |-> $stable(time_base_ff)) else $error("time base moved");
  a_osc_full_rate: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg.periph_src_select == SRC_OSC |-> periph_en) else $error("gear not bypassed");
  a_gear_full: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg.gear_code == GEAR_FULL |-> gear_en) else $error("full gear gated");
  a_run_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(cfg.divider_run) |=> running_ff) else $error("run flag late");
  a_bad_tap_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg.tap_select[3] |-> !tap_en) else $error("illegal tap ticks");
  a_div2_phi: assert property (@(posedge core_clk) disable iff (!rst_n)
    phi0_en && cfg.divider_run |=> !phi0_en) else $error("input rate too fast");
endmodule
`default_nettype wire

/* verilog/ctp_pkg.sv */
`default_nettype none
package ctp_pkg;
  // --------------------------------------------------------------------------
  // Field codes
  // --------------------------------------------------------------------------
  localparam logic [2:0] GEAR_FULL    = 3'h0;
  localparam logic [2:0] GEAR_HALF    = 3'h4;
  localparam logic [2:0] GEAR_QUARTER = 3'h6;
  localparam logic [2:0] GEAR_EIGHTH  = 3'h7;
  localparam logic [1:0] IDIV_16      = 2'h0;
  localparam logic [1:0] IDIV_8       = 2'h1;
  localparam logic [1:0] IDIV_4       = 2'h2;
  localparam logic [1:0] IDIV_2       = 2'h3;
  localparam logic       SRC_GEAR     = 1'h0;
  localparam logic       SRC_OSC      = 1'h1;
  localparam int         PRE_W        = 4;
  localparam int         CHAIN_W      = 8;
  localparam int         TB_W         = 32;

  // Configuration bits that travel together.
  typedef struct packed {
    logic       periph_src_select;
    logic [2:0] gear_code;
    logic [1:0] input_divide_select;
    logic [3:0] tap_select;
    logic       divider_run;
  } prescale_cfg_t;
endpackage
`default_nettype wire

/* verilog/rate_divider.sv */
`default_nettype none
// Counter giving one-cycle enable pulses once every 2^(k+1) enabled cycles; clear zeroes it.
module rate_divider
  import ctp_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         enable,
  input  wire logic         clear,
  output logic [W-1:0]      tick_ff
);
  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;
  logic [W-1:0] nxt_tick;

  // --------------------------------------------------------------------------
  // Counter and carry detection
  // --------------------------------------------------------------------------
  // A bit k ticks when the low k+1 bits are all ones on an enabled cycle.
  assign nxt_count = clear ? '0 : (enable ? count_ff + 1'b1 : count_ff);
  genvar k;
  generate
    for (k = 0; k < W; k++) begin : g_tick
      assign nxt_tick[k] = enable && !clear && (&count_ff[k:0]);
    end
  endgenerate

  // Registers hold count and pulses.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= '0;
      tick_ff  <= '0;
    end else begin
      count_ff <= nxt_count;
      tick_ff  <= nxt_tick;
    end
  end
endmodule
`default_nettype wire

/* dv/tb.sv */
`default_nettype none
module tb
  import ctp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Clock, reset and design
  // ------------------------------------------------------------------
  logic          core_clk = 1'b0;
  logic          rst_n    = 1'b0;
  prescale_cfg_t cfg      = '0;
  logic          tap_tick_ff;
  logic [31:0]   time_base_ff;
  logic          running_ff;
  int            err_count    = 0;
  int            total_checks = 0;
  // The clock toggles every half period of 10 ns.
  always #10 core_clk = ~core_clk;
  capture_timer_prescaler i_dut (.core_clk(core_clk), .rst_n(rst_n), .cfg(cfg),
    .tap_tick_ff(tap_tick_ff), .time_base_ff(time_base_ff), .running_ff(running_ff));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  // Compares a seen value with the expected one and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Drives a new configuration just after a rising edge.
  task automatic drive(input prescale_cfg_t v);
    @(posedge core_clk);
    #1 cfg = v;
  endtask
  // Counts edges up to the next tick; a missing tick ends the run.
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (tap_tick_ff !== 1'b1 && n < 40000);
    if (n >= 40000) begin
      err_count++;
      $display("wrong value at %0t: no tick seen", $time);
      end_of_test();
    end
  endtask
  // Clears the divider, starts it and measures one full tick period.
  task automatic run_case(input logic s, input logic [2:0] g, input logic [1:0] d,
                          input logic [3:0] t);
    int          n;
    int          gf;
    logic [31:0] base;
    gf = (s == SRC_OSC) ? 1 : (g == GEAR_HALF) ? 2 : (g == GEAR_QUARTER) ? 4 :
         (g == GEAR_EIGHTH) ? 8 : 1;
    drive('{s, g, d, t, 1'b0});
    drive('{s, g, d, t, 1'b1});
    check(32'(running_ff), 32'h0000_0000, "running while stopped");
    wait_tick(n);
    wait_tick(n);
    base = time_base_ff;
    wait_tick(n);
    check(32'(n), 32'(gf * (16 >> d) * (2 << t)), "tick period");
    check(time_base_ff, base + 32'h0000_0001, "time base step");
    $display("case src %0d gear %0d div %0d tap %0d done", s, g, d, t);
  endtask
  // Watches a stretch with no expected tick and a frozen time base.
  task automatic quiet(input prescale_cfg_t v);
    logic [31:0] base;
    drive(v);
    base = time_base_ff;
    repeat (600) begin
      @(posedge core_clk);
      #1 if (tap_tick_ff !== 1'b0) check(32'(tap_tick_ff), 32'h0000_0000, "tick");
    end
    check(time_base_ff, base, "time base held");
    check(32'(running_ff), 32'(v.divider_run), "run copy");
    $display("quiet case done");
  endtask
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  // Resets for 20 cycles, then walks both sources, every named gear and input-divide code and tap codes 0 to 8.
  initial begin
    repeat (20) @(posedge core_clk);
    check({time_base_ff[30:0], tap_tick_ff}, 32'h0000_0000, "reset value");
    #1 rst_n = 1'b1;
    run_case(SRC_OSC, GEAR_EIGHTH, IDIV_2, 4'h0);
    for (int i = 0; i < 4; i++) run_case(SRC_OSC, GEAR_FULL, 2'(i), 4'h1);
    run_case(SRC_GEAR, GEAR_FULL, IDIV_2, 4'h0);
    run_case(SRC_GEAR, GEAR_HALF, IDIV_2, 4'h0);
    run_case(SRC_GEAR, GEAR_QUARTER, IDIV_4, 4'h0);
    run_case(SRC_GEAR, GEAR_EIGHTH, IDIV_16, 4'h0);
    for (int i = 2; i < 8; i++) run_case(SRC_OSC, GEAR_FULL, IDIV_2, 4'(i));
    quiet('{SRC_OSC, GEAR_FULL, IDIV_2, 4'h0, 1'b0});
    quiet('{SRC_OSC, GEAR_FULL, IDIV_2, 4'h8, 1'b1});
    end_of_test();
  end
endmodule
`default_nettype wire
